/* File: src/pic_top.v */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pic_defines.vh"
module pic_top (
    input wire CLK,
    input wire RST_B,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output wire [1:0] S_AXI_BRESP,
    output wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0] S_AXI_RRESP,
    output wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire TMR1_REQ,
    input wire TMR0_REQ,
    input wire ADC_REQ,
    input wire [7:0] PA_IN,
    input wire CMP_OUT,
    input wire [3:0] PC_IN,
    input wire WDT_REQ,
    input wire WDT_IRQ_EN,
    input wire POSC_FAIL,
    input wire WOSC_FAIL,
    input wire ILL_INSTR,
    input wire CORE_ACK,
    input wire CORE_DISABLE_IRQ,
    input wire CORE_TRAP_INSTR,
    output wire VEC_VALID,
    output wire [15:0] VEC_ADDR,
    output wire VEC_IS_TRAP,
    output wire IRQ
);
    reg master_irq_enable_r;
    reg [`PIC_NSRC-1:0] pend_r;
    reg [2*`PIC_NSRC-1:0] level_r;
    reg [8:0] edge_r;
    reg [`PIC_NTRAP-1:0] trap_r;
    reg vec_valid_r;
    reg [15:0] vec_addr_r;
    reg vec_trap_r;
    reg [3:0] vec_idx_r;
    reg [2:0] evt_r;
    reg [2:0] evt_mask_r;
    reg irq_r;
    reg aw_hold_r;
    reg [7:0] aw_addr_r;
    reg w_hold_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;

    reg master_irq_enable_nxt;
    reg [`PIC_NSRC-1:0] pend_nxt;
    reg [`PIC_NTRAP-1:0] trap_nxt;
    reg [2:0] evt_nxt;
    reg [2:0] evt_mask_nxt;
    reg [31:0] rd_mux;
    reg rd_hit;

    wire [7:0] pa_edge;
    wire [3:0] pc_edge;
    wire [`PIC_NSRC-1:0] src_pulse;
    wire arb_valid;
    wire [3:0] arb_idx;
    wire do_wr;
    wire [31:0] wmask;
    wire wr_pend;
    wire wr_level;
    wire wr_ctrl;
    wire wr_edge;
    wire wr_evt;
    wire wr_evtmask;
    wire wr_hit;
    wire ack;
    wire trap_evt;
    wire [`PIC_NTRAP-1:0] trap_set;
    wire [`PIC_NSRC-1:0] arb_req;
    wire load_trap;
    wire load_src;
    wire lost;

    function [31:0] lane_mask;
        input [3:0] strb;
        begin
            lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    function [15:0] src_vec;
        input [3:0] idx;
        begin
            case (idx)
                `PIC_SRC_T1: src_vec = `PIC_VEC_T1;
                `PIC_SRC_T0: src_vec = `PIC_VEC_T0;
                `PIC_SRC_ADC: src_vec = `PIC_VEC_ADC;
                default:
                begin
                    if (idx < `PIC_SRC_PC3)
                        src_vec = `PIC_VEC_PA7 + {11'h000, idx - `PIC_SRC_PA7, 1'b0};
                    else
                        src_vec = `PIC_VEC_PC3 + {11'h000, idx - `PIC_SRC_PC3, 1'b0};
                end
            endcase
        end
    endfunction

    function [15:0] trap_vec;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: trap_vec = `PIC_VEC_RESET;
                3'h1: trap_vec = `PIC_VEC_WDT;
                3'h2: trap_vec = `PIC_VEC_POSC;
                3'h3: trap_vec = `PIC_VEC_WOSC;
                default: trap_vec = `PIC_VEC_ILL;
            endcase
        end
    endfunction

    function [2:0] trap_first;
        input [`PIC_NTRAP-1:0] t;
        integer k;
        begin
            trap_first = 3'h0;
            for (k = `PIC_NTRAP - 1; k >= 0; k = k - 1)
            begin
                if (t[k])
                    trap_first = k[2:0];
            end
        end
    endfunction

    pic_edge #(
        .W(8)
    ) u_pa_edge (
        .clk(CLK),
        .rst_b(RST_B),
        .din(PA_IN),
        .rise_en(~edge_r[7:0]),
        .fall_en(edge_r[7:0]),
        .pulse(pa_edge)
    );

    pic_edge #(
        .W(4)
    ) u_pc_edge (
        .clk(CLK),
        .rst_b(RST_B),
        .din(PC_IN),
        .rise_en(4'hf),
        .fall_en(4'hf),
        .pulse(pc_edge)
    );

    assign src_pulse = {pc_edge[0], pc_edge[1], pc_edge[2], pc_edge[3],
        pa_edge[0], pa_edge[1], pa_edge[2], pa_edge[3], pa_edge[4], pa_edge[5],
        (edge_r[`PIC_EDGE_CMP_BIT] ? CMP_OUT : pa_edge[6]), pa_edge[7],
        ADC_REQ, TMR0_REQ, TMR1_REQ};

    assign arb_req = pend_r & ~(~level_r[29:15] & ~level_r[14:0]);

    // Level is kept as a high half and a low half; the arbiter wants pairs.
    function [29:0] level_pairs;
        input [29:0] lv;
        integer j;
        begin
            level_pairs = 30'h00000000;
            for (j = 0; j < `PIC_NSRC; j = j + 1)
            begin
                level_pairs[2*j] = lv[j];
                level_pairs[2*j+1] = lv[15+j];
            end
        end
    endfunction

    pic_arb u_arb (
        .req(arb_req),
        .level(level_pairs(level_r)),
        .valid(arb_valid),
        .idx(arb_idx)
    );

    assign do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wmask = lane_mask(w_strb_r);
    assign wr_pend = do_wr && (aw_addr_r == `PIC_OFF_PEND);
    assign wr_level = do_wr && (aw_addr_r == `PIC_OFF_LEVEL);
    assign wr_ctrl = do_wr && (aw_addr_r == `PIC_OFF_CTRL);
    assign wr_edge = do_wr && (aw_addr_r == `PIC_OFF_EDGE);
    assign wr_evt = do_wr && (aw_addr_r == `PIC_OFF_EVT);
    assign wr_evtmask = do_wr && (aw_addr_r == `PIC_OFF_EVTMASK);
    assign wr_hit = wr_pend | wr_level | wr_ctrl | wr_edge | wr_evt | wr_evtmask
        | (aw_addr_r == `PIC_OFF_VEC);

    assign ack = CORE_ACK & vec_valid_r;

    assign trap_set = {ILL_INSTR, WOSC_FAIL, POSC_FAIL, WDT_REQ & WDT_IRQ_EN, 1'b0};
    assign trap_evt = POSC_FAIL | WOSC_FAIL | ILL_INSTR;
    assign lost = |(src_pulse & pend_r);

    assign load_trap = ~vec_valid_r & (|trap_r);
    assign load_src = ~vec_valid_r & ~(|trap_r) & master_irq_enable_r & arb_valid;

    always @*
    begin
        pend_nxt = pend_r;
        if (wr_pend)
            pend_nxt = pend_nxt & ~(wmask[`PIC_NSRC-1:0] & ~w_data_r[`PIC_NSRC-1:0]);
        if (ack && !vec_trap_r)
            pend_nxt[vec_idx_r] = 1'b0;
        pend_nxt = pend_nxt | src_pulse;

        trap_nxt = trap_r;
        if (ack && vec_trap_r)
            trap_nxt[vec_idx_r[2:0]] = 1'b0;
        trap_nxt = trap_nxt | trap_set;

        master_irq_enable_nxt = master_irq_enable_r;
        if (wr_ctrl && w_strb_r[0])
            master_irq_enable_nxt = w_data_r[`PIC_CTRL_ME_BIT];
        if (CORE_DISABLE_IRQ || CORE_TRAP_INSTR || ack || trap_evt)
            master_irq_enable_nxt = 1'b0;

        evt_nxt = evt_r;
        if (wr_evt && w_strb_r[0])
            evt_nxt = evt_nxt & ~w_data_r[2:0];
        evt_nxt = evt_nxt | {lost, trap_evt, ack};

        evt_mask_nxt = evt_mask_r;
        if (wr_evtmask && w_strb_r[0])
            evt_mask_nxt = w_data_r[2:0];
    end

    always @*
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (S_AXI_ARADDR)
            `PIC_OFF_PEND: rd_mux[`PIC_NSRC-1:0] = pend_r;
            `PIC_OFF_LEVEL: rd_mux[29:0] = level_r;
            `PIC_OFF_CTRL: rd_mux[`PIC_CTRL_ME_BIT] = master_irq_enable_r;
            `PIC_OFF_EDGE: rd_mux[8:0] = edge_r;
            `PIC_OFF_VEC: rd_mux = {3'h0, trap_r, 7'h00, vec_valid_r, vec_addr_r};
            `PIC_OFF_EVT: rd_mux[2:0] = evt_r;
            `PIC_OFF_EVTMASK: rd_mux[2:0] = evt_mask_r;
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            master_irq_enable_r <= 1'b0;
            pend_r <= 15'h0000;
            level_r <= `PIC_RST_LEVEL;
            edge_r <= `PIC_RST_EDGE;
            trap_r <= `PIC_RST_TRAP;
            evt_r <= 3'h0;
            evt_mask_r <= 3'h0;
            irq_r <= 1'b0;
        end
        else
        begin
            master_irq_enable_r <= master_irq_enable_nxt;
            pend_r <= pend_nxt;
            trap_r <= trap_nxt;
            evt_r <= evt_nxt;
            evt_mask_r <= evt_mask_nxt;
            irq_r <= |(evt_nxt & evt_mask_nxt);
            if (wr_level)
                level_r <= (level_r & ~wmask[29:0]) | (w_data_r[29:0] & wmask[29:0]);
            if (wr_edge)
                edge_r <= (edge_r & ~wmask[8:0]) | (w_data_r[8:0] & wmask[8:0]);
        end
    end

    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            vec_valid_r <= 1'b0;
            vec_addr_r <= 16'h0000;
            vec_trap_r <= 1'b0;
            vec_idx_r <= 4'h0;
        end
        else if (load_trap)
        begin
            vec_valid_r <= 1'b1;
            vec_trap_r <= 1'b1;
            vec_idx_r <= {1'b0, trap_first(trap_r)};
            vec_addr_r <= trap_vec(trap_first(trap_r));
        end
        else if (load_src)
        begin
            vec_valid_r <= 1'b1;
            vec_trap_r <= 1'b0;
            vec_idx_r <= arb_idx;
            vec_addr_r <= src_vec(arb_idx);
        end
        else if (ack)
            vec_valid_r <= 1'b0;
    end

    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_hold_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `PIC_RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `PIC_RESP_OKAY;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= {S_AXI_AWADDR[7:2], 2'b00};
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_hold_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (do_wr)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
            end
            else if (bvalid_r && S_AXI_BREADY)
                bvalid_r <= 1'b0;
            if (S_AXI_ARVALID && !rvalid_r)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
            end
            else if (rvalid_r && S_AXI_RREADY)
                rvalid_r <= 1'b0;
        end
    end

    assign S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
    assign S_AXI_WREADY = ~w_hold_r & ~bvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = ~rvalid_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    assign VEC_VALID = vec_valid_r;
    assign VEC_ADDR = vec_addr_r;
    assign VEC_IS_TRAP = vec_trap_r;
    assign IRQ = irq_r;
endmodule
`default_nettype wire

/* File: src/pic_defines.vh */
// Summary of operation
// - Three levels; level 3 beats 2 beats 1.
// - Equal level: Timer 1, Timer 0, converter, ports.
// - Reset, watchdog, oscillator and illegal traps always top.
// - Trap vectors 0002H,0004H,003AH,003CH,0006H in order.
// - Port A edges select rising/falling, vectors 0018H-0026H.
// - Vector 001AH from pin A6 or comparator.
// - Port C pins 3-0 both edges, vectors 0030H-0036H.
// - Disable, acknowledge, zero write, reset, traps except watchdog clear enable.
// - Acknowledge clears that source's request bit.
// - Writing zero to a request bit clears it.
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

`define PIC_NSRC 15
`define PIC_NTRAP 5

`define PIC_OFF_PEND 8'h00
`define PIC_OFF_LEVEL 8'h04
`define PIC_OFF_CTRL 8'h08
`define PIC_OFF_EDGE 8'h0c
`define PIC_OFF_VEC 8'h10
`define PIC_OFF_EVT 8'h14
`define PIC_OFF_EVTMASK 8'h18

`define PIC_CTRL_ME_BIT 0
`define PIC_EDGE_CMP_BIT 8
`define PIC_VEC_VALID_BIT 16
`define PIC_VEC_TRAP_LSB 24

`define PIC_EVT_ACK_BIT 0
`define PIC_EVT_TRAP_BIT 1
`define PIC_EVT_LOST_BIT 2

`define PIC_SRC_T1 4'h0
`define PIC_SRC_T0 4'h1
`define PIC_SRC_ADC 4'h2
`define PIC_SRC_PA7 4'h3
`define PIC_SRC_PC3 4'hb

`define PIC_VEC_RESET 16'h0002
`define PIC_VEC_WDT 16'h0004
`define PIC_VEC_POSC 16'h003a
`define PIC_VEC_WOSC 16'h003c
`define PIC_VEC_ILL 16'h0006
`define PIC_VEC_T1 16'h000a
`define PIC_VEC_T0 16'h000c
`define PIC_VEC_ADC 16'h0016
`define PIC_VEC_PA7 16'h0018
`define PIC_VEC_PC3 16'h0030

`define PIC_RESP_OKAY 2'b00
`define PIC_RESP_SLVERR 2'b10

`define PIC_RST_LEVEL 30'h00000000
`define PIC_RST_EDGE 9'h000
`define PIC_RST_TRAP 5'h01

`endif

/* File: src/pic_edge.v */
`timescale 1ns/10ps
`default_nettype none
module pic_edge #(
    parameter W = 8
) (
    input wire clk,
    input wire rst_b,
    input wire [W-1:0] din,
    input wire [W-1:0] rise_en,
    input wire [W-1:0] fall_en,
    output wire [W-1:0] pulse
);
    reg [W-1:0] prev_r;
    reg armed_r;

    // The first cycle after reset only samples, so a pin high at reset is no edge.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_r <= {W{1'b0}};
            armed_r <= 1'b0;
        end
        else
        begin
            prev_r <= din;
            armed_r <= 1'b1;
        end
    end

    assign pulse = {W{armed_r}} & ((din & ~prev_r & rise_en) | (~din & prev_r & fall_en));
endmodule
`default_nettype wire

/* File: src/pic_arb.v */
`timescale 1ns/10ps
`default_nettype none
`include "pic_defines.vh"
module pic_arb (
    input wire [`PIC_NSRC-1:0] req,
    input wire [2*`PIC_NSRC-1:0] level,
    output reg valid,
    output reg [3:0] idx
);
    integer l;
    integer i;

    // Later hits overwrite earlier ones: highest level, then lowest index.
    always @*
    begin
        valid = 1'b0;
        idx = 4'h0;
        for (l = 1; l <= 3; l = l + 1)
        begin
            for (i = `PIC_NSRC - 1; i >= 0; i = i - 1)
            begin
                if (req[i] && (level[2*i +: 2] == l[1:0]))
                begin
                    valid = 1'b1;
                    idx = i[3:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/pic_chk_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module pic_chk (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CORE_ACK,
    input wire logic VEC_VALID,
    input wire logic [15:0] VEC_ADDR,
    input wire logic VEC_IS_TRAP
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    sequence s_wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_vec_taken;
        VEC_VALID && CORE_ACK;
    endsequence
    chk_ack_clears_vec: assert property (s_vec_taken |=> !VEC_VALID)
        else $error("vector still valid after acknowledge");
    chk_vec_held: assert property (
        VEC_VALID && !CORE_ACK |=> VEC_VALID && $stable(VEC_ADDR))
        else $error("vector changed before acknowledge");
    chk_trap_vec: assert property (VEC_VALID && VEC_IS_TRAP |->
        VEC_ADDR inside {16'h0002, 16'h0004, 16'h003a, 16'h003c, 16'h0006})
        else $error("trap vector outside the trap set");
    chk_irq_vec: assert property (VEC_VALID && !VEC_IS_TRAP |-> !VEC_ADDR[0] &&
        VEC_ADDR inside {16'h000a, 16'h000c, [16'h0016:16'h0026], [16'h0030:16'h0036]})
        else $error("interrupt vector outside the source set");
    chk_reset_vec: assert property ($rose(RST_B) |->
        ##[0:2] (VEC_VALID && VEC_IS_TRAP && VEC_ADDR == 16'h0002))
        else $error("reset vector not presented after reset");
    chk_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped before taken");
    chk_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped before taken");
    chk_write_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID)
        else $error("write response late");
endmodule
bind pic_top pic_chk i_chk (.CLK(CLK), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .CORE_ACK(CORE_ACK), .VEC_VALID(VEC_VALID), .VEC_ADDR(VEC_ADDR),
    .VEC_IS_TRAP(VEC_IS_TRAP));
`default_nettype wire

/* File: verif/pic_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pic_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic vec_valid,
    input wire logic [15:0] vec_addr,
    input wire logic vec_is_trap,
    input wire logic [3:0] dly,
    output logic core_ack,
    output logic [15:0] last_addr,
    output logic last_trap,
    output logic [7:0] n_ack
);
    int wait_c;
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {core_ack, last_addr, last_trap, n_ack} <= '0;
            wait_c <= 0;
        end
        else if (core_ack)
        begin
            core_ack <= 1'b0;
            {last_addr, last_trap} <= {vec_addr, vec_is_trap};
            n_ack <= n_ack + 8'h1;
            wait_c <= 0;
        end
        else if (vec_valid && wait_c >= int'(dly))
            core_ack <= 1'b1;
        else if (vec_valid)
            wait_c <= wait_c + 1;
    end
endmodule
`default_nettype wire

/* File: verif/priority_interrupt_controller_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_controller_tb;
    logic clk, rst_b, awv, wv, bready, arv, rready, t1, t0, adc, wdt_en;
    logic [7:0] awaddr, araddr, pa;
    logic [31:0] wdata, rd_d;
    logic [3:0] wstrb, pc, dly;
    logic [1:0] rd_r;
    logic [6:0] tr;
    wire logic awrdy, wrdy, bvalid, arrdy, rvalid, core_ack, vvalid, vtrap, irq, ltrap;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] vaddr, laddr;
    wire logic [7:0] n_ack;
    int mismatches, n_compared, j;
    logic [15:0] rows [15] = '{16'h000a, 16'h000c, 16'h0016, 16'h0018, 16'h001a, 16'h001c,
        16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0030, 16'h0032, 16'h0034, 16'h0036};
    logic [15:0] traps [4] = '{16'h0004, 16'h003a, 16'h003c, 16'h0006};
    logic [15:0] lv [4] = '{16'h0036, 16'h000c, 16'h0016, 16'h000a};
    pic_top i_dut (.CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TMR1_REQ(t1),
        .TMR0_REQ(t0), .ADC_REQ(adc), .PA_IN(pa), .CMP_OUT(tr[6]), .PC_IN(pc), .WDT_REQ(tr[0]),
        .WDT_IRQ_EN(wdt_en), .POSC_FAIL(tr[1]), .WOSC_FAIL(tr[2]), .ILL_INSTR(tr[3]),
        .CORE_ACK(core_ack), .CORE_DISABLE_IRQ(tr[4]), .CORE_TRAP_INSTR(tr[5]),
        .VEC_VALID(vvalid), .VEC_ADDR(vaddr), .VEC_IS_TRAP(vtrap), .IRQ(irq));
    pic_core_model i_core (.clk(clk), .rst_b(rst_b), .vec_valid(vvalid), .vec_addr(vaddr),
        .vec_is_trap(vtrap), .dly(dly), .core_ack(core_ack), .last_addr(laddr),
        .last_trap(ltrap), .n_ack(n_ack));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        {awaddr, awv, wdata, wv, wstrb, bready} <= {a, 1'b1, d, 1'b1, s, 1'b1};
        do
        begin
            @(posedge clk);
            if (awrdy)
                awv <= 1'b0;
            if (wrdy)
                wv <= 1'b0;
        end while (!bvalid);
        rd_r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, 4'hf);
    endtask
    task automatic axr(input logic [7:0] a);
        {araddr, arv, rready} <= {a, 2'b11};
        do
        begin
            @(posedge clk);
            if (arrdy)
                arv <= 1'b0;
        end while (!rvalid);
        {rd_d, rd_r} = {rdata, rresp};
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk(rd_d, e);
    endtask
    task automatic pulse(input logic [14:0] m, input logic [6:0] t);
        {t1, t0, adc, tr} <= {m[0], m[1], m[2], t};
        pa <= pa ^ {m[3], m[4], m[5], m[6], m[7], m[8], m[9], m[10]};
        pc <= pc ^ {m[11], m[12], m[13], m[14]};
        @(posedge clk);
        {t1, t0, adc, tr} <= '0;
    endtask
    task automatic take(input logic [15:0] e);
        logic [7:0] k;
        k = n_ack;
        while (n_ack == k)
            @(posedge clk);
        chk({16'h0, laddr}, {16'h0, e});
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        {awaddr, araddr, wdata, wstrb, awv, wv, bready, arv, rready} = '0;
        {t1, t0, adc, tr, pa, pc, wdt_en, dly, rst_b} = '0;
        {mismatches, n_compared} = '0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        take(16'h0002);
        chk({31'h0, ltrap}, 32'h1);
        for (j = 0; j < 32; j += 4)
            if (j != 16 && j != 20)
                rdc(j[7:0], 32'h0);
        $display("reset test done");
        wr(8'h04, 32'h0000_7fff);
        for (j = 0; j < 15; j++)
        begin
            dly <= {2'b00, j[1:0]};
            wr(8'h08, 32'h1);
            pulse(15'h1 << j, 7'h0);
            take(rows[j]);
        end
        pa <= 8'h00;
        repeat (4) @(posedge clk);
        rdc(8'h00, 32'h0);
        wr(8'h0c, 32'h0000_00ff);
        pa <= 8'hff;
        repeat (4) @(posedge clk);
        rdc(8'h00, 32'h0);
        pa <= 8'h00;
        repeat (4) @(posedge clk);
        rdc(8'h00, 32'h0000_07f8);
        wr(8'h00, 32'h0);
        wr(8'h0c, 32'h0);
        axw(8'h04, 32'hffff_ffff, 4'h2);
        rdc(8'h04, 32'h0000_ffff);
        $display("vector table test done");
        wr(8'h04, 32'h2003_4001);
        pulse(15'h4007, 7'h0);
        rdc(8'h00, 32'h0000_4007);
        for (j = 0; j < 4; j++)
        begin
            wr(8'h08, 32'h1);
            take(lv[j]);
            rdc(8'h08, 32'h0);
        end
        rdc(8'h00, 32'h0);
        wr(8'h04, 32'h0000_7fff);
        wr(8'h0c, 32'h100);
        wr(8'h08, 32'h1);
        pulse(15'h0, 7'h40);
        take(16'h001a);
        pulse(15'h4, 7'h0);
        rdc(8'h00, 32'h4);
        wr(8'h00, 32'h0);
        rdc(8'h00, 32'h0);
        wr(8'h08, 32'h1);
        repeat (4) @(posedge clk);
        chk({31'h0, vvalid}, 32'h0);
        $display("level test done");
        for (j = 4; j < 6; j++)
        begin
            wr(8'h08, 32'h1);
            pulse(15'h0, 7'h1 << j);
            rdc(8'h08, 32'h0);
        end
        wr(8'h08, 32'h1);
        wr(8'h08, 32'h0);
        rdc(8'h08, 32'h0);
        wdt_en <= 1'b1;
        wr(8'h08, 32'h1);
        pulse(15'h0, 7'h0f);
        for (j = 0; j < 4; j++)
            take(traps[j]);
        rdc(8'h08, 32'h0);
        for (j = 0; j < 2; j++)
        begin
            wr(8'h18, 32'h1 << j);
            chk({31'h0, irq}, 32'h1);
            wr(8'h14, 32'h1 << j);
            chk({31'h0, irq}, 32'h0);
        end
        axw(8'h1c, 32'h1, 4'hf);
        chk({30'h0, rd_r}, 32'h2);
        axr(8'h1c);
        chk({30'h0, rd_r}, 32'h2);
        $display("trap and event test done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        take(16'h0002);
        rdc(8'h08, 32'h0);
        $display("second reset test done");
        print_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict;
    end
endmodule
`default_nettype wire
